/* verilog/evt_pkg.sv */
// Constants, field layouts and carrier types for the 8-bit event timer.
// Assumes a single core_clk domain and an APB master with 32-bit data.
//
// Summary of operation
// - Counter equals constant B sets match flag B
// - Counter equals constant A sets match flag A
// - Counter wrap from FF to 00 sets flag
// - Flags clear by writing 0 after reading 1
// - Reserved status and trigger bits read one
// - Match B drives pin: hold, 0, 1, toggle
// - Match A drives pin with same encoding
// - Pin low after reset; A and B independent
// - Trigger edge: off, rising, falling, both
// - Trigger enable gates start and halt behaviour
// - Halt after clear, resume on trigger edge
// - Internal select bit refines clock select field
// - Counting begins once valid clock is selected
// - Wrap requests interrupt when its enable set
// - Match fires in last cycle of equality
// - Matches request interrupts when enables set
// - Clear select 01/10 clears on match A/B
// - Clear select 11 clears on reset pin rise
// - Prescaled clocks /4 to /128, external edges
// - Simultaneous matches: toggle over 1 over 0
package evt_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] EVT_OFF_COUNT = 8'h00;
  localparam logic [7:0] EVT_OFF_CONST_A = 8'h04;
  localparam logic [7:0] EVT_OFF_CONST_B = 8'h08;
  localparam logic [7:0] EVT_OFF_CTRL0 = 8'h0C;
  localparam logic [7:0] EVT_OFF_STATUS = 8'h10;
  localparam logic [7:0] EVT_OFF_CTRL1 = 8'h14;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] EVT_RST_COUNT = 8'h00;
  localparam logic [7:0] EVT_RST_CONST = 8'hFF;
  localparam logic [7:0] EVT_COUNT_MAX = 8'hFF;
  localparam int EVT_BIT_FLAG_B = 7;
  localparam int EVT_BIT_FLAG_A = 6;
  localparam int EVT_BIT_WRAP = 5;
  localparam logic [7:0] EVT_STATUS_RSVD = 8'h10;
  localparam logic [7:0] EVT_CTRL1_RSVD = 8'hE2;
  localparam int EVT_DIV_W = 7;

  // Pin output actions (output-select encoding)
  localparam logic [1:0] EVT_ACT_HOLD = 2'h0;
  localparam logic [1:0] EVT_ACT_LOW = 2'h1;
  localparam logic [1:0] EVT_ACT_HIGH = 2'h2;
  localparam logic [1:0] EVT_ACT_TOGGLE = 2'h3;

  // Clear select encoding
  localparam logic [1:0] EVT_CLR_NONE = 2'h0;
  localparam logic [1:0] EVT_CLR_MATCH_A = 2'h1;
  localparam logic [1:0] EVT_CLR_MATCH_B = 2'h2;
  localparam logic [1:0] EVT_CLR_PIN = 2'h3;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic match_b_interrupt_enable;
    logic match_a_interrupt_enable;
    logic wrap_interrupt_enable;
    logic [1:0] clear_select;
    logic [2:0] clock_select;
  } evt_ctrl0_t;

  typedef struct packed {
    logic [1:0] trigger_edge;
    logic trigger_enable;
    logic internal_clock_select;
  } evt_ctrl1_t;

  typedef struct packed {
    logic match_flag_b;
    logic match_flag_a;
    logic wrap_flag;
    logic [1:0] output_select_b;
    logic [1:0] output_select_a;
  } evt_status_t;

endpackage

/* verilog/evt_timer.sv */
// 8-bit event timer with two compare registers, waveform pin and trigger.
// Assumes an APB master on core_clk; the three input pins are asynchronous.
`timescale 1ns/1ps

module evt_timer
  import evt_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_clock_pin,
  input wire logic counter_reset_pin,
  input wire logic trigger_pin,
  output logic waveform_out_pin,
  output logic irq_match_a,
  output logic irq_match_b,
  output logic irq_wrap
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] count_q; // event_counter
  logic [7:0] const_a_q; // constant_register_a
  logic [7:0] const_b_q; // constant_register_b
  evt_ctrl0_t ctrl0_q; // primary_timer_control
  evt_ctrl1_t ctrl1_q; // trigger_and_clock_control
  evt_status_t status_q; // timer_status_output_select
  logic [2:0] armed_q; // Flag seen as 1 by a status read (B, A, wrap)
  logic run_q; // Trigger gate: counting allowed
  logic [EVT_DIV_W-1:0] div_q; // Free-running prescaler
  logic src_lvl_q; // Previous selected source level
  logic [2:0] sync1_q; // First synchroniser stage, read only by stage two
  logic [2:0] sync2_q; // Second synchroniser stage
  logic [2:0] pin_prev_q; // Delayed stage two for edge detection

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic setup_ph;
  logic wr_fire;
  logic rd_fire;
  logic wr_count;
  logic wr_const_a;
  logic wr_const_b;
  logic wr_ctrl0;
  logic wr_status;
  logic wr_ctrl1;
  logic rd_status;
  logic addr_ok;

  // Setup cycle is when read data and the answer are prepared
  assign setup_ph = psel & ~penable;
  // Access edge at which the registered ready is sampled high
  assign wr_fire = psel & penable & pready & pwrite;
  assign rd_fire = psel & penable & pready & ~pwrite;
  assign addr_ok = (paddr == EVT_OFF_COUNT) | (paddr == EVT_OFF_CONST_A) | (paddr == EVT_OFF_CONST_B) |
                   (paddr == EVT_OFF_CTRL0) | (paddr == EVT_OFF_STATUS) | (paddr == EVT_OFF_CTRL1);
  assign wr_count = wr_fire & (paddr == EVT_OFF_COUNT);
  assign wr_const_a = wr_fire & (paddr == EVT_OFF_CONST_A);
  assign wr_const_b = wr_fire & (paddr == EVT_OFF_CONST_B);
  assign wr_ctrl0 = wr_fire & (paddr == EVT_OFF_CTRL0);
  assign wr_status = wr_fire & (paddr == EVT_OFF_STATUS);
  assign wr_ctrl1 = wr_fire & (paddr == EVT_OFF_CTRL1);
  assign rd_status = rd_fire & (paddr == EVT_OFF_STATUS);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pin_raw;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;

  assign pin_raw = {trigger_pin, counter_reset_pin, external_clock_pin};

  // Two flops per pin, then a third for edge detection
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_sync
      always_ff @(posedge core_clk)
      begin
        if (sys_rst)
        begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
          pin_prev_q[gi] <= 1'b0;
        end
        else
        begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
          pin_prev_q[gi] <= sync2_q[gi];
        end
      end
      assign pin_rise[gi] = sync2_q[gi] & ~pin_prev_q[gi];
      assign pin_fall[gi] = ~sync2_q[gi] & pin_prev_q[gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Clock source selection
  // ----------------------------------------------------------------
  logic [2:0] div_idx;
  logic src_int;
  logic src_lvl;
  logic count_tick;

  // Prescaler taps /4 up to /128 from the select pair
  always_comb
  begin
    div_idx = 3'({ctrl0_q.clock_select[1:0] - 2'd1, ctrl1_q.internal_clock_select}) + 3'd1;
    src_int = (ctrl0_q.clock_select[2] == 1'b0) && (ctrl0_q.clock_select[1:0] != 2'd0);
    src_lvl = src_int ? div_q[div_idx] : 1'b0;
  end

  // Free-running prescaler
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      div_q <= '0;
    else
      div_q <= div_q + 1'b1;
  end

  // Falling-edge history of the selected internal tap
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      src_lvl_q <= 1'b0;
    else
      src_lvl_q <= src_lvl;
  end

  // Count request; a tap switch that looks like a fall counts too
  always_comb
  begin
    case (ctrl0_q.clock_select)
      3'h5: count_tick = pin_rise[0];
      3'h6: count_tick = pin_fall[0];
      3'h7: count_tick = pin_rise[0] | pin_fall[0];
      3'h1, 3'h2, 3'h3: count_tick = src_lvl_q & ~src_lvl;
      default: count_tick = 1'b0; // Clock input prohibited
    endcase
  end

  // ----------------------------------------------------------------
  // Compare, clear and trigger
  // ----------------------------------------------------------------
  logic inc;
  logic eq_a;
  logic eq_b;
  logic match_a;
  logic match_b;
  logic clr;
  logic wrap;
  logic trig_edge;

  always_comb
  begin
    // Counting is gated only while trigger mode is on
    inc = count_tick & (run_q | ~ctrl1_q.trigger_enable);
    eq_a = (count_q == const_a_q);
    eq_b = (count_q == const_b_q);
    // Match in the last cycle of equality; a constant write inhibits it
    match_a = eq_a & inc & ~wr_const_a;
    match_b = eq_b & inc & ~wr_const_b;
    // Counter clear sources
    case (ctrl0_q.clear_select)
      EVT_CLR_MATCH_A: clr = match_a;
      EVT_CLR_MATCH_B: clr = match_b;
      EVT_CLR_PIN: clr = pin_rise[1];
      default: clr = 1'b0;
    endcase
    wrap = inc & (count_q == EVT_COUNT_MAX) & ~clr;
    // Trigger edge selection
    case (ctrl1_q.trigger_edge)
      2'h1: trig_edge = pin_rise[2];
      2'h2: trig_edge = pin_fall[2];
      2'h3: trig_edge = pin_rise[2] | pin_fall[2];
      default: trig_edge = 1'b0;
    endcase
  end

  // Counter: clear beats a bus write, a bus write beats an increment
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      count_q <= EVT_RST_COUNT;
    else if (clr)
      count_q <= EVT_RST_COUNT;
    else if (wr_count)
      count_q <= pwdata[7:0];
    else if (inc)
      count_q <= count_q + 8'h01;
  end

  // Halt after a clear, restart on the chosen trigger edge
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      run_q <= 1'b1;
    else if (!ctrl1_q.trigger_enable)
      run_q <= 1'b1;
    else if (trig_edge)
      run_q <= 1'b1;
    else if (clr)
      run_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Constant and control registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      const_a_q <= EVT_RST_CONST;
      const_b_q <= EVT_RST_CONST;
    end
    else
    begin
      if (wr_const_a)
        const_a_q <= pwdata[7:0];
      if (wr_const_b)
        const_b_q <= pwdata[7:0];
    end
  end

  // Control registers; reserved control bits are not stored
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      ctrl0_q <= '0;
      ctrl1_q <= '0;
    end
    else
    begin
      if (wr_ctrl0)
        ctrl0_q <= evt_ctrl0_t'(pwdata[7:0]);
      if (wr_ctrl1)
        ctrl1_q <= evt_ctrl1_t'({pwdata[4:2], pwdata[0]});
    end
  end

  // ----------------------------------------------------------------
  // Status flags and output selects
  // ----------------------------------------------------------------
  logic [2:0] flag_set;
  logic [2:0] flag_clr;

  assign flag_set = {match_b, match_a, wrap};
  // Only a 0 written after a read of 1 clears; all else leaves the flag
  assign flag_clr = {3{wr_status}} & ~pwdata[7:5] & armed_q;

  // Set wins over a clear in the same cycle
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      status_q <= '0;
    end
    else
    begin
      status_q.match_flag_b <= flag_set[2] | (status_q.match_flag_b & ~flag_clr[2]);
      status_q.match_flag_a <= flag_set[1] | (status_q.match_flag_a & ~flag_clr[1]);
      status_q.wrap_flag <= flag_set[0] | (status_q.wrap_flag & ~flag_clr[0]);
      if (wr_status)
      begin
        status_q.output_select_b <= pwdata[3:2];
        status_q.output_select_a <= pwdata[1:0];
      end
    end
  end

  // Arm only the flags that the read returned as 1; disarm on their clear
  // The live flags could already hold a set that the reader never saw
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      armed_q <= '0;
    else if (rd_status)
      armed_q <= prdata[7:5];
    else
      armed_q <= armed_q & ~flag_clr;
  end

  // ----------------------------------------------------------------
  // Waveform pin
  // ----------------------------------------------------------------
  logic [1:0] act_a;
  logic [1:0] act_b;
  logic do_tog;
  logic do_high;
  logic do_low;

  // Combine both actions, toggle over 1 over 0
  always_comb
  begin
    act_a = match_a ? status_q.output_select_a : EVT_ACT_HOLD;
    act_b = match_b ? status_q.output_select_b : EVT_ACT_HOLD;
    do_tog = (act_a == EVT_ACT_TOGGLE) | (act_b == EVT_ACT_TOGGLE);
    do_high = (act_a == EVT_ACT_HIGH) | (act_b == EVT_ACT_HIGH);
    do_low = (act_a == EVT_ACT_LOW) | (act_b == EVT_ACT_LOW);
  end

  // Pin stays low from reset until the first match acts
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      waveform_out_pin <= 1'b0;
    else if (do_tog)
      waveform_out_pin <= ~waveform_out_pin;
    else if (do_high)
      waveform_out_pin <= 1'b1;
    else if (do_low)
      waveform_out_pin <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Interrupt requests
  // ----------------------------------------------------------------
  // Levels follow flag and enable, one cycle behind for a clean flop output
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      irq_match_a <= 1'b0;
      irq_match_b <= 1'b0;
      irq_wrap <= 1'b0;
    end
    else
    begin
      irq_match_a <= status_q.match_flag_a & ctrl0_q.match_a_interrupt_enable;
      irq_match_b <= status_q.match_flag_b & ctrl0_q.match_b_interrupt_enable;
      irq_wrap <= status_q.wrap_flag & ctrl0_q.wrap_interrupt_enable;
    end
  end

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;

  // Read data; reserved bits always read as one
  always_comb
  begin
    case (paddr)
      EVT_OFF_COUNT: rd_mux = count_q;
      EVT_OFF_CONST_A: rd_mux = const_a_q;
      EVT_OFF_CONST_B: rd_mux = const_b_q;
      EVT_OFF_CTRL0: rd_mux = ctrl0_q;
      EVT_OFF_STATUS: rd_mux = {status_q[6:4], 1'b0, status_q[3:0]} | EVT_STATUS_RSVD;
      EVT_OFF_CTRL1: rd_mux = {3'b000, ctrl1_q[3:1], 1'b0, ctrl1_q[0]} | EVT_CTRL1_RSVD;
      default: rd_mux = 8'h00;
    endcase
  end

  // Answer prepared in setup, so ready is high in the first access cycle.
  // Status is sampled one cycle early; a flag set in that cycle is not armed,
  // so it cannot be cleared by a write that never saw it.
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (setup_ph)
    begin
      prdata <= {24'h00_0000, rd_mux};
      pready <= 1'b1;
      pslverr <= ~addr_ok;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule

/* tb/evt_timer_properties.sv */
// Port-level assertions for the event timer.
// Assumes one core_clk domain and a synchronous active-high sys_rst.
`timescale 1ns/1ps
module evt_timer_properties
  import evt_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic external_clock_pin,
  input wire logic counter_reset_pin,
  input wire logic trigger_pin,
  input wire logic waveform_out_pin,
  input wire logic irq_match_a,
  input wire logic irq_match_b,
  input wire logic irq_wrap
);
  // ------------------------------------------------------------
  // Bus handshake, read-back, reset outputs and interrupt drop
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // Setup phase of a read from one word
  sequence rd_setup(logic [7:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence
  ready_after_setup_a: assert property (psel && !penable |=> pready) // Zero wait states
    else $error("pready missing after setup");
  ready_one_cycle_a: assert property (pready |=> !pready) // Single-cycle answer
    else $error("pready held too long");
  error_reads_zero_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000) // Refused word
    else $error("pslverr without pready or with data");
  upper_bytes_zero_a: assert property (pready |-> prdata[31:8] == 24'h00_0000) // Low byte only
    else $error("prdata upper bytes not zero");
  status_rsvd_one_a: assert property (rd_setup(EVT_OFF_STATUS) ##1 pready |-> prdata[4])
    else $error("status reserved bit read as zero");
  trig_rsvd_ones_a: assert property (rd_setup(EVT_OFF_CTRL1) ##1 pready |-> prdata[7:5] == 3'h7 && prdata[1])
    else $error("trigger control reserved bits read as zero");
  reset_quiet_a: assert property ($fell(sys_rst) |-> !waveform_out_pin && !irq_match_a && !irq_match_b && !irq_wrap)
    else $error("outputs active right after reset");
  irq_drop_write_a: assert property ($fell(irq_match_a) || $fell(irq_match_b) || $fell(irq_wrap) |-> $past(psel && penable && pwrite, 2))
    else $error("interrupt dropped without a register write");
endmodule

bind evt_timer evt_timer_properties i_evt_timer_properties (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .external_clock_pin(external_clock_pin), .counter_reset_pin(counter_reset_pin),
  .trigger_pin(trigger_pin), .waveform_out_pin(waveform_out_pin), .irq_match_a(irq_match_a),
  .irq_match_b(irq_match_b), .irq_wrap(irq_wrap));

/* tb/evt_pin_model.sv */
// Model of the external pins that feed the event timer.
// Assumes the bench toggles a request level to ask for each pin event.
`timescale 1ns/1ps
module evt_pin_model
(
  input wire logic core_clk,
  input wire logic trig_req,
  input wire logic rst_req,
  input wire logic ext_req,
  output logic external_clock_pin,
  output logic counter_reset_pin,
  output logic trigger_pin
);
  // ------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------
  logic rst_seen_q = 1'b0; // Last reset request served
  logic [2:0] rst_cnt_q = 3'h0; // Remaining pulse cycles
  // External clock follows its request level, so it stands still between edges
  always_ff @(posedge core_clk)
    external_clock_pin <= ext_req;
  // One trigger edge per request, far apart in time
  always_ff @(posedge core_clk)
    trigger_pin <= trig_req;
  // Reset pulse of four clocks, well above the minimum width
  always_ff @(posedge core_clk)
  begin
    if (rst_req != rst_seen_q)
    begin
      rst_seen_q <= rst_req;
      rst_cnt_q <= 3'h4;
    end
    else if (rst_cnt_q != 3'h0)
      rst_cnt_q <= rst_cnt_q - 3'h1;
  end
  assign counter_reset_pin = (rst_cnt_q != 3'h0);
endmodule

/* tb/evt_timer_test.sv */
// Self-checking bench for the event timer.
// Assumes evt_pkg, the pin model and the bound checker are compiled first.
`timescale 1ns/1ps
module evt_timer_test;
  import evt_pkg::*;
  // ------------------------------------------------------------
  // Signals and bookkeeping
  // ------------------------------------------------------------
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, ext_clk, rst_pin, trg_pin, wave, irq_a, irq_b, irq_w;
  logic trig_req = 1'b0; // Toggled to ask for one trigger edge
  logic rst_req = 1'b0; // Toggled to ask for one reset pulse
  logic ext_req = 1'b0; // Toggled to ask for one external clock edge
  logic [8:0] exp_q[$]; // Expected {pslverr, data} per read
  logic [1:0] acts[8] = '{EVT_ACT_LOW, EVT_ACT_HIGH, EVT_ACT_TOGGLE, EVT_ACT_HOLD,
                          EVT_ACT_TOGGLE, EVT_ACT_LOW, EVT_ACT_TOGGLE, EVT_ACT_HIGH};
  int err_count = 0;
  int comparisons = 0;
  int seed = 32'h0b6d;
  always #2 core_clk = ~core_clk;
  evt_timer i_evt_timer (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_clock_pin(ext_clk), .counter_reset_pin(rst_pin), .trigger_pin(trg_pin),
    .waveform_out_pin(wave), .irq_match_a(irq_a), .irq_match_b(irq_b), .irq_wrap(irq_w));
  evt_pin_model i_evt_pin_model (.core_clk(core_clk), .trig_req(trig_req), .rst_req(rst_req), .ext_req(ext_req),
    .external_clock_pin(ext_clk), .counter_reset_pin(rst_pin), .trigger_pin(trg_pin));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results();
    $display("Comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      err_count++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [8:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 8'h00);
  endtask
  // Bounded wait for one interrupt line: 0 match A, 1 match B, 2 wrap
  task automatic wait_irq(input int w);
    int n;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (!(w == 0 ? irq_a : (w == 1 ? irq_b : irq_w)) && n < 2000);
    check("interrupt", {8'h00, n < 2000}, 9'h001);
  endtask
  // Read monitor: oldest note against each completed read (tags at rd calls)
  always @(posedge core_clk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      check("read data", {pslverr, prdata[7:0]}, exp_q.pop_front());
  end
  // Watchdog, far beyond the expected run length
  initial
  begin
    #(4 * 40000);
    err_count++;
    $display("Watchdog expired");
    results();
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    logic [7:0] cv, st;
    logic [1:0] act, edg;
    logic ch, expw;
    expw = 1'b0;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(EVT_OFF_COUNT, {1'b0, EVT_RST_COUNT});
    rd(EVT_OFF_CONST_A, {1'b0, EVT_RST_CONST});
    rd(EVT_OFF_CONST_B, {1'b0, EVT_RST_CONST});
    rd(EVT_OFF_CTRL0, 9'h000);
    rd(EVT_OFF_STATUS, {1'b0, EVT_STATUS_RSVD});
    rd(EVT_OFF_CTRL1, {1'b0, EVT_CTRL1_RSVD});
    rd(8'h18, 9'h100);
    check("waveform", {8'h00, wave}, 9'h000);
    $display("Test reset values done");
    // Match, pin action, clear, halt and trigger restart on A and B in turn
    for (int i = 0; i < 8; i++)
    begin
      ch = i[0];
      act = acts[i];
      cv = 8'h04 + 8'($random(seed) & 32'h0000_003f);
      edg = trig_req ? 2'h2 : (i == 4 ? 2'h3 : 2'h1);
      apb(1'b1, ch ? EVT_OFF_CONST_B : EVT_OFF_CONST_A, cv);
      apb(1'b1, ch ? EVT_OFF_CONST_A : EVT_OFF_CONST_B, 8'hff);
      apb(1'b1, EVT_OFF_STATUS, {3'h7, 1'b1, ch ? act : 2'h0, ch ? 2'h0 : act});
      apb(1'b1, EVT_OFF_CTRL1, {3'h0, edg, 1'b1, 2'h0});
      apb(1'b1, EVT_OFF_CTRL0, {ch, ~ch, 1'b0, ch ? EVT_CLR_MATCH_B : EVT_CLR_MATCH_A, 3'h1});
      trig_req <= ~trig_req;
      wait_irq(ch ? 1 : 0);
      expw = act == EVT_ACT_TOGGLE ? ~expw : (act == EVT_ACT_HIGH ? 1'b1 : (act == EVT_ACT_LOW ? 1'b0 : expw));
      st = {ch, ~ch, 1'b0, 1'b1, ch ? act : 2'h0, ch ? 2'h0 : act};
      rd(EVT_OFF_STATUS, {1'b0, st});
      apb(1'b1, EVT_OFF_STATUS, st & 8'h1f);
      rd(EVT_OFF_COUNT, 9'h000);
      rd(EVT_OFF_STATUS, {1'b0, st & 8'h1f});
      check("waveform", {8'h00, wave}, {8'h00, expw});
      check("match irqs", {7'h00, irq_b, irq_a}, 9'h000);
    end
    $display("Test compare matches done");
    // Wrap from FF with both constants at FF, trigger gate off
    apb(1'b1, EVT_OFF_CTRL0, 8'h21);
    apb(1'b1, EVT_OFF_STATUS, 8'h10);
    apb(1'b1, EVT_OFF_CONST_A, 8'hff);
    apb(1'b1, EVT_OFF_CONST_B, 8'hff);
    apb(1'b1, EVT_OFF_COUNT, 8'hfe);
    apb(1'b1, EVT_OFF_CTRL1, 8'h00);
    wait_irq(2);
    apb(1'b1, EVT_OFF_STATUS, 8'h10);
    rd(EVT_OFF_STATUS, 9'h0f0);
    apb(1'b1, EVT_OFF_STATUS, 8'h10);
    rd(EVT_OFF_STATUS, 9'h010);
    check("wrap irq", {8'h00, irq_w}, 9'h000);
    $display("Test wrap done");
    // Clear from the reset pin with the clock stopped
    apb(1'b1, EVT_OFF_CTRL0, 8'h18);
    apb(1'b1, EVT_OFF_COUNT, 8'h50);
    rd(EVT_OFF_COUNT, 9'h050);
    rst_req <= ~rst_req;
    repeat (10) @(posedge core_clk);
    rd(EVT_OFF_COUNT, 9'h000);
    $display("Test reset pin done");
    // External clock on both edges, then on rising edges only
    apb(1'b1, EVT_OFF_CTRL0, 8'h07);
    apb(1'b1, EVT_OFF_COUNT, 8'h00);
    for (int k = 0; k < 12; k++)
    begin
      if (k == 6)
        apb(1'b1, EVT_OFF_CTRL0, 8'h05);
      ext_req <= ~ext_req;
      repeat (8) @(posedge core_clk);
      if (k == 5)
        rd(EVT_OFF_COUNT, 9'h006);
    end
    rd(EVT_OFF_COUNT, 9'h009);
    $display("Test external clock done");
    // Both matches at once with clashing actions, internal clock /8
    apb(1'b1, EVT_OFF_CTRL1, 8'h01);
    apb(1'b1, EVT_OFF_CONST_A, 8'h10);
    apb(1'b1, EVT_OFF_CONST_B, 8'h10);
    for (int j = 0; j < 2; j++)
    begin
      st = j ? 8'hdb : 8'hd9;
      apb(1'b1, EVT_OFF_STATUS, st | 8'he0);
      apb(1'b1, EVT_OFF_COUNT, 8'h00);
      apb(1'b1, EVT_OFF_CTRL0, 8'h49);
      wait_irq(0);
      apb(1'b1, EVT_OFF_CTRL0, 8'h08);
      rd(EVT_OFF_STATUS, {1'b0, st});
      apb(1'b1, EVT_OFF_STATUS, st & 8'h1f);
      check("waveform", {8'h00, wave}, {8'h00, j == 0});
    end
    $display("Test simultaneous matches done");
    results();
  end
endmodule
